// ==== hw/power_good_regs.vh ====
`ifndef POWER_GOOD_REGS_VH
`define POWER_GOOD_REGS_VH

// register offsets in the device register bank
`define OUT_A_SELECT_ADDR   8'h18
`define OUT_A_FAULT_ADDR    8'h19
`define OUT_B_SELECT_ADDR   8'h1A
`define OUT_B_FAULT_ADDR    8'h1B

// field positions
`define RISE_HOLD_BIT       7
`define THERMAL_BIT         6
`define SOURCE_MSB          6

// reset values
`define SELECT_RESET        8'h00
`define FAULT_RESET         7'h00

// timing
`define CORE_CLK_MHZ        50
`define RISE_HOLD_US        11000
`define RISE_HOLD_CYCLES    (`RISE_HOLD_US * `CORE_CLK_MHZ)
`define RISE_CNT_W          20

`endif

// ==== hw/power_good_channel.v ====
`timescale 1ns/1ns
`include "power_good_regs.vh"

module power_good_channel #(
  parameter [`RISE_CNT_W-1:0] HOLD_CYCLES = `RISE_HOLD_CYCLES
) (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // synchronised source status, 1 = valid
  input  wire [6:0] source_valid,
  // configuration
  input  wire [6:0] source_select,
  input  wire       rise_hold,
  input  wire       latched_fault_gating,
  input  wire       polarity,
  // write-one-to-clear of the fault flags
  input  wire       fault_clear_wr,
  input  wire [6:0] fault_clear_mask,
  // status and output
  output reg  [6:0] fault_flag,
  output reg        power_good_out
);

  //////////////////////////////////////////////////////////////////////////////
  wire [6:0]            bad_now   = source_select & ~source_valid;
  wire                  live_ok   = ~|bad_now;
  wire [6:0]            clear_now = {7{fault_clear_wr}} & fault_clear_mask & source_valid;
  // a new fault in the same cycle as its clear wins
  wire [6:0]            next_fault = bad_now | (fault_flag & ~clear_now);
  wire                  sources_ok = latched_fault_gating ? ~|next_fault : live_ok;
  reg  [`RISE_CNT_W-1:0] hold_cnt;
  reg                   good;

  always @(posedge core_clk) begin
    if (rst) begin
      fault_flag <= `FAULT_RESET;
    end else begin
      fault_flag <= next_fault;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // any failure drops the output at once and restarts the hold count
  always @(posedge core_clk) begin
    if (rst) begin
      hold_cnt <= {`RISE_CNT_W{1'b0}};
      good     <= 1'b0;
    end else if (!sources_ok) begin
      hold_cnt <= {`RISE_CNT_W{1'b0}};
      good     <= 1'b0;
    end else if (!rise_hold) begin
      good     <= 1'b1;
    end else if (hold_cnt >= HOLD_CYCLES - 1'b1) begin
      good     <= 1'b1;
    end else if (!good) begin
      hold_cnt <= hold_cnt + 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      power_good_out <= 1'b0;
    end else begin
      power_good_out <= good ^ polarity;
    end
  end

endmodule

// ==== hw/power_good_aggregator.v ====
`timescale 1ns/1ns
`include "power_good_regs.vh"

// Contract
// - output A rise held 11 ms when enabled
// - output B rise held 11 ms when enabled
// - bit 6 includes thermal warning for A
// - bit 6 includes thermal warning for B
// - bits 5..0 select sources for A
// - bits 5..0 select sources for B
// - A fault flag set when source drops A
// - flag cleared by writing one while valid
// - unset flags and bit 7 read zero
// - select bits load from one-time memory
// - output B has matching sticky fault flags
// - gating bit picks live or latched status
// - polarity bit inverts output level

module power_good_aggregator #(
  parameter [`RISE_CNT_W-1:0] HOLD_CYCLES = `RISE_HOLD_CYCLES
) (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // register bank port
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // asynchronous source status, 1 = valid:
  // thermal, analog supply, monitor 2, monitor 1, boost, buck 1, buck 0
  input  wire [6:0] source_valid_pin,
  // power-up defaults from one-time-programmable memory
  input  wire [6:0] otp_out_a_select,
  input  wire [6:0] otp_out_b_select,
  // output control bits held elsewhere in the register bank
  input  wire       out_a_latched_fault_gating,
  input  wire       out_b_latched_fault_gating,
  input  wire       out_a_polarity,
  input  wire       out_b_polarity,
  // power-good outputs
  output wire       power_good_out_a,
  output wire       power_good_out_b
);

  //////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser; analog comparators are not on core_clk
  reg  [6:0] valid_meta;
  reg  [6:0] valid_sync;

  always @(posedge core_clk) begin
    if (rst) begin
      valid_meta <= 7'h7F;
      valid_sync <= 7'h7F;
    end else begin
      valid_meta <= source_valid_pin;
      valid_sync <= valid_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers; select bits are loaded from the memory one cycle
  // after reset release, since an async capture would need a port value
  reg  [7:0] out_a_select;
  reg  [7:0] out_b_select;
  reg        otp_loaded;
  wire [6:0] fault_a;
  wire [6:0] fault_b;

  always @(posedge core_clk) begin
    if (rst) begin
      out_a_select <= `SELECT_RESET;
      out_b_select <= `SELECT_RESET;
      otp_loaded   <= 1'b0;
    end else if (!otp_loaded) begin
      otp_loaded   <= 1'b1;
      out_a_select <= {1'b0, otp_out_a_select};
      out_b_select <= {1'b0, otp_out_b_select};
    end else if (reg_wr) begin
      if (reg_addr == `OUT_A_SELECT_ADDR) begin
        out_a_select <= reg_wdata;
      end
      if (reg_addr == `OUT_B_SELECT_ADDR) begin
        out_b_select <= reg_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `OUT_A_SELECT_ADDR: reg_rdata <= out_a_select;
        `OUT_A_FAULT_ADDR:  reg_rdata <= {1'b0, fault_a};
        `OUT_B_SELECT_ADDR: reg_rdata <= out_b_select;
        `OUT_B_FAULT_ADDR:  reg_rdata <= {1'b0, fault_b};
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  power_good_channel #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) channel_a (
    .core_clk             (core_clk),
    .rst                  (rst),
    .source_valid         (valid_sync),
    .source_select        (out_a_select[`SOURCE_MSB:0]),
    .rise_hold            (out_a_select[`RISE_HOLD_BIT]),
    .latched_fault_gating (out_a_latched_fault_gating),
    .polarity             (out_a_polarity),
    .fault_clear_wr       (reg_wr && otp_loaded && reg_addr == `OUT_A_FAULT_ADDR),
    .fault_clear_mask     (reg_wdata[6:0]),
    .fault_flag           (fault_a),
    .power_good_out       (power_good_out_a)
  );

  power_good_channel #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) channel_b (
    .core_clk             (core_clk),
    .rst                  (rst),
    .source_valid         (valid_sync),
    .source_select        (out_b_select[`SOURCE_MSB:0]),
    .rise_hold            (out_b_select[`RISE_HOLD_BIT]),
    .latched_fault_gating (out_b_latched_fault_gating),
    .polarity             (out_b_polarity),
    .fault_clear_wr       (reg_wr && otp_loaded && reg_addr == `OUT_B_FAULT_ADDR),
    .fault_clear_mask     (reg_wdata[6:0]),
    .fault_flag           (fault_b),
    .power_good_out       (power_good_out_b)
  );

endmodule

// ==== testbench/power_good_checker_properties.sv ====
`timescale 1ns/1ns
`include "power_good_regs.vh"
module power_good_checker #(
  parameter [`RISE_CNT_W-1:0] HOLD_CYCLES = `RISE_HOLD_CYCLES
) (
  // clock, reset, register bank
  input wire       core_clk,
  input wire       rst,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // sources, defaults, control, outputs
  input wire [6:0] source_valid_pin,
  input wire [6:0] otp_out_a_select,
  input wire [6:0] otp_out_b_select,
  input wire       out_a_latched_fault_gating,
  input wire       out_b_latched_fault_gating,
  input wire       out_a_polarity,
  input wire       out_b_polarity,
  input wire       power_good_out_a,
  input wire       power_good_out_b
);
  // quiet cycles with all sources valid under live gating; saturates
  reg [20:0] calm_a;
  reg [20:0] calm_b;
  always @(posedge core_clk) begin
    if (rst || source_valid_pin != 7'h7F || out_a_latched_fault_gating || $changed(out_a_polarity))
      calm_a <= 21'h0;
    else if (!calm_a[20])
      calm_a <= calm_a + 21'h1;
    if (rst || source_valid_pin != 7'h7F || out_b_latched_fault_gating || $changed(out_b_polarity))
      calm_b <= 21'h0;
    else if (!calm_b[20])
      calm_b <= calm_b + 21'h1;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_unmapped_reads_zero: assert property (!(reg_addr inside {[8'h18:8'h1B]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read nonzero");
  chk_reserved_bit_zero: assert property (reg_addr == 8'h19 || reg_addr == 8'h1B |=> !reg_rdata[7])
    else $error("fault bit 7 set");
  chk_sel_a_readback: assert property (!$past(rst) && reg_wr && reg_addr == 8'h18 ##1 !reg_wr && reg_addr == 8'h18
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("select a readback wrong");
  chk_sel_b_readback: assert property (!$past(rst) && reg_wr && reg_addr == 8'h1A ##1 !reg_wr && reg_addr == 8'h1A
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("select b readback wrong");
  chk_otp_load_a: assert property ($fell(rst) && reg_addr == 8'h18 ##1 reg_addr == 8'h18
    |=> reg_rdata == {1'b0, $past(otp_out_a_select, 2)})
    else $error("otp default not loaded");
  chk_rise_a_bound: assert property (calm_a > {1'b0, HOLD_CYCLES} + 21'd8 |-> power_good_out_a == !out_a_polarity)
    else $error("output a not active");
  chk_rise_b_bound: assert property (calm_b > {1'b0, HOLD_CYCLES} + 21'd8 |-> power_good_out_b == !out_b_polarity)
    else $error("output b not active");
  chk_gated_flag_low: assert property (reg_addr == 8'h19 && !reg_wr && out_a_latched_fault_gating
    ##1 reg_rdata[6:0] != 7'h00
    |=> power_good_out_a == $past(out_a_polarity))
    else $error("gated output a active");
  cover property ($fell(power_good_out_a));
  cover property ($rose(power_good_out_b));
  cover property (reg_wr && reg_addr == 8'h19);
endmodule
bind power_good_aggregator power_good_checker #(.HOLD_CYCLES(HOLD_CYCLES)) u_power_good_checker (.*);

// ==== testbench/pg_receiver.sv ====
`timescale 1ns/1ns
module pg_receiver (
  // power-good pins and their polarity
  input  wire       power_good_out_a,
  input  wire       power_good_out_b,
  input  wire       out_a_polarity,
  input  wire       out_b_polarity,
  // supply-valid view of the receiving processor
  output wire [1:0] supply_ok
);
  assign supply_ok = {power_good_out_b ^ out_b_polarity, power_good_out_a ^ out_a_polarity};
endmodule

// ==== testbench/power_good_aggregator_tb.sv ====
`timescale 1ns/1ns
module power_good_aggregator_tb;
  reg        core_clk = 1'b0;
  reg        rst = 1'b1;
  reg        reg_wr = 1'b0;
  reg  [7:0] reg_addr = 8'h18;
  reg  [7:0] reg_wdata = 8'h00;
  reg  [7:0] lfsr = 8'h45;
  reg  [6:0] source_valid_pin = 7'h7F;
  reg  [6:0] otp_out_a_select = 7'h2B;
  reg  [6:0] otp_out_b_select = 7'h54;
  reg        out_a_latched_fault_gating = 1'b0;
  reg        out_b_latched_fault_gating = 1'b0;
  reg        out_a_polarity = 1'b0;
  reg        out_b_polarity = 1'b0;
  reg  [6:0] sa;
  reg  [6:0] sb;
  wire [7:0] reg_rdata;
  wire       power_good_out_a;
  wire       power_good_out_b;
  wire [1:0] supply_ok;
  integer    n_mismatch = 0;
  integer    n_compared = 0;
  integer    i;
  always #10 core_clk = ~core_clk;
  power_good_aggregator #(.HOLD_CYCLES(20'h14)) u_power_good_aggregator (.*);
  pg_receiver u_pg_receiver (.*);
  ////////////////////////////////////////
  function [7:0] nxt(input [7:0] v);
    nxt = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function [7:0] bad(input [6:0] s);
    bad = {1'b0, s & ~source_valid_pin};
  endfunction
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      // one idle edge so a following write never re-raises the strobe in the same step
      @(negedge core_clk);
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      reg_addr = a;
      repeat (2) @(negedge core_clk);
      check(reg_rdata, exp);
    end
  endtask
  task final_report;
    begin
      if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    rd(8'h18, {1'b0, otp_out_a_select});
    rd(8'h1A, {1'b0, otp_out_b_select});
    rd(8'h1B, 8'h00);
    rd(8'h1C, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      lfsr = nxt(lfsr);
      sa = (i == 0) ? 7'h40 : lfsr[6:0];
      lfsr = nxt(lfsr);
      sb = (i == 0) ? 7'h40 : lfsr[6:0];
      lfsr = nxt(lfsr);
      wr(8'h18, {1'b0, sa});
      wr(8'h1A, {1'b0, sb});
      source_valid_pin = (i == 0) ? 7'h3F : lfsr[6:0];
      repeat (6) @(negedge core_clk);
      check({6'h00, supply_ok}, {6'h00, bad(sb) == 8'h00, bad(sa) == 8'h00});
      wr(8'h19, 8'hFF);
      rd(8'h19, bad(sa));
      rd(8'h1B, bad(sb));
      source_valid_pin = 7'h7F;
      wr(8'h19, 8'h00);
      rd(8'h19, {1'b0, sa & ~((i == 0) ? 7'h3F : lfsr[6:0])});
      check({6'h00, supply_ok}, 8'h03);
      wr(8'h19, 8'hFF);
      wr(8'h1B, 8'hFF);
      rd(8'h19, 8'h00);
    end
    wr(8'h18, 8'h81);
    wr(8'h1A, 8'h81);
    source_valid_pin = 7'h7E;
    repeat (6) @(negedge core_clk);
    source_valid_pin = 7'h7F;
    repeat (20) @(negedge core_clk);
    check({6'h00, supply_ok}, 8'h00);
    repeat (8) @(negedge core_clk);
    check({6'h00, supply_ok}, 8'h03);
    out_a_latched_fault_gating = 1'b1;
    out_a_polarity = 1'b1;
    out_b_latched_fault_gating = 1'b1;
    out_b_polarity = 1'b1;
    rd(8'h19, 8'h01);
    check({6'h00, power_good_out_b, power_good_out_a}, 8'h03);
    wr(8'h19, 8'hFF);
    repeat (30) @(negedge core_clk);
    check({6'h00, power_good_out_b, power_good_out_a}, 8'h02);
    final_report;
  end
endmodule
